// file: obc_fetch.sv
// sequencer that reads both option bytes from flash once after reset
`timescale 1ns/1ps
module obc_fetch
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	output logic      [15:0] flash_addr,
	output logic             flash_rd,
	input  wire logic  [7:0] flash_rdata,
	input  wire logic        flash_rvalid,
	output logic       [7:0] pri_byte,
	output logic       [7:0] wdg_byte,
	output logic             done
);

	// whole state of the sequencer
	typedef struct packed {
		obc_pkg::obc_fetch_e st;   // sequencer state
		logic [15:0]         addr; // address offered to flash
		logic                rd;   // one-cycle read strobe
		logic [7:0]          pri;  // captured primary byte
		logic [7:0]          wdg;  // captured watchdog byte
		logic                done; // both bytes captured
	} obc_fetch_s;

	obc_fetch_s st_ff;
	obc_fetch_s nxt_st;

	// next state: strobe, wait, capture, then stay idle until next reset
	always_comb
	begin
		nxt_st    = st_ff;
		nxt_st.rd = 1'b0;
		case (st_ff.st)
			obc_pkg::FS_RD_PRI:
			begin
				nxt_st.addr = obc_pkg::FLASH_ADDR_PRI; // [RQ1]
				nxt_st.rd   = 1'b1;
				nxt_st.st   = obc_pkg::FS_WAIT_PRI;
			end
			obc_pkg::FS_WAIT_PRI:
			begin
				if (flash_rvalid)
				begin
					nxt_st.pri = flash_rdata;
					nxt_st.st  = obc_pkg::FS_RD_WDG;
				end
			end
			obc_pkg::FS_RD_WDG:
			begin
				nxt_st.addr = obc_pkg::FLASH_ADDR_WDG; // [RQ1]
				nxt_st.rd   = 1'b1;
				nxt_st.st   = obc_pkg::FS_WAIT_WDG;
			end
			obc_pkg::FS_WAIT_WDG:
			begin
				if (flash_rvalid)
				begin
					nxt_st.wdg  = flash_rdata;
					nxt_st.done = 1'b1;
					nxt_st.st   = obc_pkg::FS_DONE;
				end
			end
			default:
			begin
				// later flash changes are never looked at again
				nxt_st.st = obc_pkg::FS_DONE; // [RQ16]
			end
		endcase
	end

	// register, erased defaults while reset holds
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_ff.st   <= obc_pkg::FS_RD_PRI;
			st_ff.addr <= obc_pkg::FLASH_ADDR_PRI;
			st_ff.rd   <= 1'b0;
			st_ff.pri  <= obc_pkg::ERASED_BYTE; // [RQ10]
			st_ff.wdg  <= obc_pkg::ERASED_BYTE; // [RQ10]
			st_ff.done <= 1'b0;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	assign flash_addr = st_ff.addr;
	assign flash_rd   = st_ff.rd;
	assign pri_byte   = st_ff.pri;
	assign wdg_byte   = st_ff.wdg;
	assign done       = st_ff.done;

endmodule

// file: obc_flash_model.sv
// flash array model answering option byte reads after a set latency
`timescale 1ns/1ps
module obc_flash_model
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [15:0] flash_addr,
	input  wire logic        flash_rd,
	input  wire logic  [7:0] pri_byte,
	input  wire logic  [7:0] wdg_byte,
	input  wire logic  [3:0] lat,
	output logic       [7:0] flash_rdata,
	output logic             flash_rvalid
);
	logic  [4:0] cnt_ff;  // cycles left until the answer
	logic [15:0] addr_ff; // address of the pending read

	// one answer per request; data line toggles when not answering
	always_ff @(posedge aclk)
	begin
		flash_rvalid <= 1'b0;
		flash_rdata  <= ~flash_rdata;
		if (!aresetn)
		begin
			cnt_ff      <= 5'h00;
			flash_rdata <= 8'h5a;
		end
		else if (flash_rd)
		begin
			cnt_ff  <= {1'b0, lat} + 5'h01;
			addr_ff <= flash_addr;
		end
		else if (cnt_ff != 5'h00)
		begin
			cnt_ff <= cnt_ff - 5'h01;
			if (cnt_ff == 5'h01)
			begin
				flash_rvalid <= 1'b1;
				// bytes taken from the pri_byte and wdg_byte inputs when answering; blank places read ff
				flash_rdata  <= (addr_ff == 16'hffff) ? pri_byte :
					(addr_ff == 16'hffdb) ? wdg_byte : 8'hff;
			end
		end
	end
endmodule

// file: obc_loader.sv
// option byte loader top: decode, gate and axi4-lite register access
`timescale 1ns/1ps

// Function
// RQ1 - fetch bytes from FFFFh and FFDBh
// RQ2 - b0 zero autostarts watchdog
// RQ3 - b2 zero disables rom protection
// RQ4 - b3 zero protects when b2 set
// RQ5 - protection blocks parallel mode rewrite
// RQ6 - b5:b4 pick detection level code
// RQ7 - one level for monitor and power-on
// RQ8 - b6 zero enables monitor reset
// RQ9 - b7 zero enables count source protection
// RQ10 - erased bytes read FFh, safe defaults
// RQ11 - programmer writes each byte once
// RQ12 - b1:b0 pick watchdog initial count
// RQ13 - b3:b2 pick refresh window percent
// RQ14 - window measured against full count
// RQ15 - 00h then FFh reloads watchdog
// RQ16 - latch once per reset, hold
// RQ17 - reserved bits ignored when decoding
module obc_loader
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// flash array read port
	output logic      [15:0] flash_addr,
	output logic             flash_rd,
	input  wire logic  [7:0] flash_rdata,
	input  wire logic        flash_rvalid,
	// axi4-lite slave
	input  wire logic [17:0] s_axi_awaddr,
	input  wire logic  [2:0] s_axi_awprot,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic  [3:0] s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic       [1:0] s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [17:0] s_axi_araddr,
	input  wire logic  [2:0] s_axi_arprot,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic      [31:0] s_axi_rdata,
	output logic       [1:0] s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// parallel programming gate
	input  wire logic        par_write_req,
	output logic             par_write_allow,
	// decoded configuration
	output logic             config_valid,
	output logic             watchdog_autostart,
	output logic      [13:0] watchdog_initial,
	output logic       [1:0] refresh_window,
	output logic             watchdog_reload,
	output logic             source_protect_en,
	output logic             monitor_reset_en,
	output logic       [1:0] monitor_level,
	output logic       [1:0] por_level,
	output logic             rom_protect_active
);

	// whole state of the top
	typedef struct packed {
		// write address and data holding
		logic        aw_full;   // write address held
		logic [17:0] aw_addr;   // held write address
		logic        w_full;    // write data held
		logic [31:0] w_data;    // held write data
		logic  [3:0] w_strb;    // held byte enables
		logic        awready;   // address channel ready
		logic        wready;    // data channel ready
		logic        bvalid;    // write response valid
		logic  [1:0] bresp;     // write response code
		// read side
		logic        arready;   // read address ready
		logic        rvalid;    // read data valid
		logic [31:0] rdata;     // read data
		logic  [1:0] rresp;     // read response code
		// refresh write strobe to detector
		logic        ref_wr;    // refresh byte written
		logic  [7:0] ref_data;  // byte written
		// decoded outputs
		logic        valid;     // configuration latched
		logic        autostart; // watchdog autostart
		logic [13:0] init_cnt;  // watchdog initial count
		logic  [1:0] window;    // refresh window code
		logic        src_prot;  // count source protection
		logic        mon_en;    // monitor reset enable
		logic  [1:0] level;     // detection level code
		logic        protect;   // rom protection in force
		logic        allow;     // parallel rewrite allowed
		logic        reload;    // reload pulse, registered
	} obc_top_s;

	obc_top_s st_ff;
	obc_top_s nxt_st;

	// fetch results and the refresh detector pulse
	logic  [7:0] pri_byte;   // latched primary byte
	logic  [7:0] wdg_byte;   // latched watchdog byte
	logic        fetch_done; // both bytes latched
	logic        reload_p;   // refresh sequence complete

	// flash fetch sequencer, runs once after each reset
	obc_fetch u_fetch
	(
		.aclk         (aclk),
		.aresetn      (aresetn),
		.flash_addr   (flash_addr),
		.flash_rd     (flash_rd),
		.flash_rdata  (flash_rdata),
		.flash_rvalid (flash_rvalid),
		.pri_byte     (pri_byte),
		.wdg_byte     (wdg_byte),
		.done         (fetch_done)
	);

	// watchdog refresh sequence detector
	obc_refresh u_refresh
	(
		.aclk     (aclk),
		.aresetn  (aresetn),
		.wr_valid (st_ff.ref_wr),
		.wr_data  (st_ff.ref_data),
		.reload   (reload_p)
	);

	// underflow period code to initial count
	function automatic logic [13:0] init_of(input logic [1:0] code);
		logic [13:0] v;
		// shortest period unless the code picks another
		v = obc_pkg::WDT_INIT_0;
		case (code)
			2'h1:    v = obc_pkg::WDT_INIT_1;
			2'h2:    v = obc_pkg::WDT_INIT_2;
			2'h3:    v = obc_pkg::WDT_INIT_3;
			default: v = obc_pkg::WDT_INIT_0;
		endcase
		return v;
	endfunction

	// register word read at a given byte address
	function automatic logic [32:0] read_word(input logic [17:0] a,
		input obc_top_s s, input logic [7:0] pb, input logic [7:0] wb);
		logic [32:0] r;
		r = '0;
		if (a == {obc_pkg::IDX_OPT_WDG[15:0], 2'b00})
		begin
			// watchdog option byte, upper lanes zero
			r = {1'b1, 24'h00_0000, wb};
		end
		else if (a == {obc_pkg::IDX_OPT_PRI[15:0], 2'b00})
		begin
			// primary option byte, upper lanes zero
			r = {1'b1, 24'h00_0000, pb};
		end
		else if (a == {obc_pkg::IDX_STATUS[15:0], 2'b00})
		begin
			// status flags, unused bits read zero
			r = '0;
			r[32] = 1'b1;
			r[obc_pkg::ST_LOADED]  = s.valid;
			r[obc_pkg::ST_PROTECT] = s.protect;
			r[obc_pkg::ST_GRANT]   = s.allow;
		end
		else if (a == {obc_pkg::IDX_REFRESH[15:0], 2'b00})
		begin
			// refresh register is write-only, reads zero
			r = {1'b1, 32'h0000_0000};
		end
		else
		begin
			// unmapped
			r = '0;
		end
		return r;
	endfunction

	// bus handshakes, decode and configuration decode
	always_comb
	begin
		logic        do_wr;   // both halves of a write held
		logic [32:0] rd;      // read lookup result
		logic        prot;    // protection decode
		do_wr = 1'b0;
		rd    = '0;
		prot  = 1'b0;
		// hold everything unless a branch below moves it
		nxt_st        = st_ff;
		nxt_st.ref_wr = 1'b0;

		// write address channel capture
		if (s_axi_awvalid && st_ff.awready)
		begin
			nxt_st.aw_full = 1'b1;
			nxt_st.aw_addr = s_axi_awaddr;
		end
		// write data channel capture, either order
		if (s_axi_wvalid && st_ff.wready)
		begin
			nxt_st.w_full = 1'b1;
			nxt_st.w_data = s_axi_wdata;
			nxt_st.w_strb = s_axi_wstrb;
		end

		// perform the write once both halves are held
		do_wr = st_ff.aw_full && st_ff.w_full && !st_ff.bvalid;
		if (do_wr)
		begin
			// both halves consumed, response follows
			nxt_st.aw_full = 1'b0;
			nxt_st.w_full  = 1'b0;
			nxt_st.bvalid  = 1'b1;
			if (st_ff.aw_addr == {obc_pkg::IDX_REFRESH[15:0], 2'b00})
			begin
				// only the low lane carries the refresh byte
				nxt_st.bresp = obc_pkg::RESP_OKAY;
				nxt_st.ref_wr   = st_ff.w_strb[0];
				nxt_st.ref_data = st_ff.w_data[7:0];
			end
			else if (st_ff.aw_addr ==
				{obc_pkg::IDX_STATUS[15:0], 2'b00})
			begin
				// status is read-only, write ignored
				nxt_st.bresp = obc_pkg::RESP_OKAY;
			end
			else
			begin
				// option bytes live in flash, unmapped too
				nxt_st.bresp = obc_pkg::RESP_SLVERR;
			end
		end
		// write response handshake
		if (st_ff.bvalid && s_axi_bready)
		begin
			nxt_st.bvalid = 1'b0;
		end
		// channel readiness, one write in flight
		nxt_st.awready = !nxt_st.aw_full && !nxt_st.bvalid
			&& !(s_axi_awvalid && st_ff.awready);
		nxt_st.wready  = !nxt_st.w_full && !nxt_st.bvalid
			&& !(s_axi_wvalid && st_ff.wready);

		// read address taken, data answered the next cycle
		if (s_axi_arvalid && st_ff.arready)
		begin
			// word looked up while the address is taken
			rd = read_word(s_axi_araddr, st_ff, pri_byte, wdg_byte);
			nxt_st.arready = 1'b0;
			nxt_st.rvalid  = 1'b1;
			nxt_st.rdata   = rd[31:0];
			nxt_st.rresp   = rd[32] ? obc_pkg::RESP_OKAY
				: obc_pkg::RESP_SLVERR;
		end
		else if (st_ff.rvalid && s_axi_rready)
		begin
			// data accepted, next address may come
			nxt_st.rvalid  = 1'b0;
			nxt_st.arready = 1'b1;
		end

		// configuration decode, only after both bytes latched
		if (fetch_done)
		begin
			nxt_st.valid     = 1'b1; // [RQ16]
			// active-low autostart bit
			nxt_st.autostart = !pri_byte[obc_pkg::PRI_AUTOSTART_N]; // [RQ2]
			// b2 low wins over b3, else b3 low protects
			prot = pri_byte[obc_pkg::PRI_PROT_CTRL]
				&& !pri_byte[obc_pkg::PRI_ROM_PROT_N]; // [RQ3] [RQ4]
			nxt_st.protect   = prot;
			// one level code feeds both detectors
			nxt_st.level     = {pri_byte[obc_pkg::PRI_LEVEL_HI],
				pri_byte[obc_pkg::PRI_LEVEL_LO]}; // [RQ6]
			// enable bits are active low in flash
			nxt_st.mon_en    = !pri_byte[obc_pkg::PRI_MON_OFF]; // [RQ8]
			nxt_st.src_prot  = !pri_byte[obc_pkg::PRI_SRC_OFF]; // [RQ9]
			// reserved bits, primary b1 and watchdog b7:b4, are never read
			nxt_st.init_cnt  = init_of({wdg_byte[obc_pkg::WDG_UFLOW_HI],
				wdg_byte[obc_pkg::WDG_UFLOW_LO]}); // [RQ12] [RQ17]
			// window code against the full count to underflow
			nxt_st.window    = {wdg_byte[obc_pkg::WDG_WIN_HI],
				wdg_byte[obc_pkg::WDG_WIN_LO]}; // [RQ13] [RQ14]
		end

		// parallel rewrite only while unprotected and loaded
		nxt_st.allow  = par_write_req && nxt_st.valid
			&& !nxt_st.protect; // [RQ5]
		// reload forwarded only once configuration is valid
		nxt_st.reload = reload_p && st_ff.valid; // [RQ15]
	end

	// register, erased-byte defaults until configuration latches
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_ff           <= '0;
			// all channels ready out of reset
			st_ff.awready   <= 1'b1;
			st_ff.wready    <= 1'b1;
			st_ff.arready   <= 1'b1;
			// watchdog stopped, protection off, as erased
			st_ff.init_cnt  <= obc_pkg::WDT_INIT_3; // [RQ10]
			// window and level codes of the erased bytes
			st_ff.window    <= {obc_pkg::ERASED_BYTE[obc_pkg::WDG_WIN_HI],
				obc_pkg::ERASED_BYTE[obc_pkg::WDG_WIN_LO]};
			st_ff.level     <= {obc_pkg::ERASED_BYTE[obc_pkg::PRI_LEVEL_HI],
				obc_pkg::ERASED_BYTE[obc_pkg::PRI_LEVEL_LO]};
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	// outputs straight from flops
	// bus channel outputs
	assign s_axi_awready      = st_ff.awready;
	assign s_axi_wready       = st_ff.wready;
	assign s_axi_bvalid       = st_ff.bvalid;
	assign s_axi_bresp        = st_ff.bresp;
	assign s_axi_arready      = st_ff.arready;
	assign s_axi_rvalid       = st_ff.rvalid;
	assign s_axi_rdata        = st_ff.rdata;
	assign s_axi_rresp        = st_ff.rresp;
	// gate and decoded configuration
	assign par_write_allow    = st_ff.allow;
	assign config_valid       = st_ff.valid;
	assign watchdog_autostart = st_ff.autostart;
	assign watchdog_initial   = st_ff.init_cnt;
	assign refresh_window     = st_ff.window;
	assign watchdog_reload    = st_ff.reload;
	assign source_protect_en  = st_ff.src_prot;
	assign monitor_reset_en   = st_ff.mon_en;
	// one level feeds both detectors
	assign monitor_level      = st_ff.level; // [RQ7]
	assign por_level          = st_ff.level; // [RQ7]
	assign rom_protect_active = st_ff.protect;

endmodule

// file: obc_loader_checker.sv
// port assertions for the option byte loader
`timescale 1ns/1ps
module obc_loader_checker
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [15:0] flash_addr,
	input wire logic        flash_rd,
	input wire logic        par_write_req,
	input wire logic        par_write_allow,
	input wire logic        config_valid,
	input wire logic        watchdog_autostart,
	input wire logic [13:0] watchdog_initial,
	input wire logic  [1:0] refresh_window,
	input wire logic        watchdog_reload,
	input wire logic  [1:0] monitor_level,
	input wire logic  [1:0] por_level,
	input wire logic        rom_protect_active
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_one_level;
		por_level == monitor_level;
	endproperty
	a_one_level: assert property (p_one_level)
		else $error("level codes differ");
	property p_gate_open;
		$past(par_write_req) && $past(config_valid)
			&& !$past(rom_protect_active) |-> par_write_allow;
	endproperty
	a_gate_open: assert property (p_gate_open)
		else $error("rewrite not allowed while unprotected");
	property p_gate_shut;
		par_write_allow |-> config_valid && !rom_protect_active;
	endproperty
	a_gate_shut: assert property (p_gate_shut)
		else $error("rewrite allowed while protected");
	property p_hold;
		$past(config_valid) |-> config_valid && $stable(watchdog_initial)
			&& $stable(monitor_level) && $stable(rom_protect_active)
			&& $stable(watchdog_autostart) && $stable(refresh_window);
	endproperty
	a_hold: assert property (p_hold)
		else $error("configuration moved after load");
	property p_no_refetch;
		config_valid |-> !flash_rd;
	endproperty
	a_no_refetch: assert property (p_no_refetch)
		else $error("flash read after load");
	property p_addr;
		flash_rd |-> flash_addr == 16'hffff || flash_addr == 16'hffdb;
	endproperty
	a_addr: assert property (p_addr)
		else $error("flash read at wrong address");
	property p_defaults;
		!config_valid |-> watchdog_initial == 14'h3fff
			&& refresh_window == 2'h3 && !watchdog_autostart;
	endproperty
	a_defaults: assert property (p_defaults)
		else $error("outputs not at erased values");
	property p_reload;
		watchdog_reload |-> config_valid ##1 !watchdog_reload;
	endproperty
	a_reload: assert property (p_reload)
		else $error("reload pulse malformed");

	c_loaded: cover property ($rose(config_valid));
	c_reload: cover property (watchdog_reload);
	c_allow: cover property (par_write_allow);
endmodule

bind obc_loader obc_loader_checker u_chk
(
	.aclk, .aresetn, .flash_addr, .flash_rd, .par_write_req, .par_write_allow,
	.config_valid, .watchdog_autostart, .watchdog_initial, .refresh_window,
	.watchdog_reload, .monitor_level, .por_level, .rom_protect_active
);

// file: obc_loader_tb_top.sv
// self-checking bench for the option byte loader
`timescale 1ns/1ps
module obc_loader_tb_top;
	logic        aclk, aresetn, flash_rd, flash_rvalid, par_write_req;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, par_write_allow, config_valid;
	logic        watchdog_autostart, watchdog_reload, source_protect_en;
	logic        monitor_reset_en, rom_protect_active;
	logic  [1:0] s_axi_bresp, s_axi_rresp, refresh_window, monitor_level;
	logic  [1:0] por_level, rsp;
	logic  [3:0] s_axi_wstrb, lat;
	logic  [7:0] flash_rdata, pb, wb, fp, fw;
	logic [13:0] watchdog_initial;
	logic [15:0] flash_addr;
	logic [17:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd, want;
	logic [31:0] seed = 32'h0001_07d7; // fixed random start
	logic [15:0] corner [4] = '{16'hffff, 16'h0000, 16'h04f0, 16'h0c05};
	int          bad_count, check_count, rl_cnt, rl0, n;

	obc_loader dut
	(
		.aclk, .aresetn, .flash_addr, .flash_rd, .flash_rdata, .flash_rvalid,
		.s_axi_awaddr, .s_axi_awprot(3'b000), .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'b000),
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .par_write_req, .par_write_allow,
		.config_valid, .watchdog_autostart, .watchdog_initial, .refresh_window,
		.watchdog_reload, .source_protect_en, .monitor_reset_en, .monitor_level,
		.por_level, .rom_protect_active
	);
	obc_flash_model u_flash
	(
		.aclk, .aresetn, .flash_addr, .flash_rd, .pri_byte(fp), .wdg_byte(fw),
		.lat, .flash_rdata, .flash_rvalid
	);

	// clock at 5 ns
	initial
	begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	// counts reload pulses
	always @(posedge aclk)
		if (watchdog_reload === 1'b1)
			rl_cnt++;

	// xorshift step
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic prot(input logic [7:0] p);
		return p[2] & ~p[3];
	endfunction
	// expected decoded outputs from the two bytes
	function automatic logic [31:0] exp_cfg(input logic [7:0] p, w,
		input logic v);
		logic [13:0] c;
		case (w[1:0])
			2'b00: c = 14'h03ff;
			2'b01: c = 14'h0fff;
			2'b10: c = 14'h1fff;
			default: c = 14'h3fff;
		endcase
		return {7'h00, v, ~p[0], prot(p), ~p[6], ~p[7], p[5:4], p[5:4],
			w[3:2], c};
	endfunction
	function automatic logic [31:0] got_cfg();
		return {7'h00, config_valid, watchdog_autostart, rom_protect_active,
			monitor_reset_en, source_protect_en, monitor_level, por_level,
			refresh_window, watchdog_initial};
	endfunction

	task automatic chk_cfg(input logic [31:0] got, exp);
		check_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t: config %h want %h", $time, got, exp);
		end
	endtask
	task automatic chk_bus(input logic [33:0] got, exp);
		check_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t: bus %h want %h", $time, got, exp);
		end
	endtask

	// one write, address and data offered together
	task automatic axi_wr(input logic [17:0] a, input logic [7:0] d,
		output logic [1:0] r);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h00_0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(aw && w) && n < 100)
		begin
			@(posedge aclk);
			n++;
			if (!aw && s_axi_awready)
			begin
				aw = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w && s_axi_wready)
			begin
				w = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (!s_axi_bvalid && ++n < 100);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		chk_bus(34'(n < 100), 34'h1);
	endtask
	// one read, result left in rd
	task automatic axi_rd(input logic [17:0] a, output logic [1:0] r);
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (!s_axi_rvalid && n < 100);
		rd = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		chk_bus(34'(n < 100), 34'h1);
	endtask

	task automatic results();
		if (bad_count == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// hang guard
	initial
	begin
		#60000;
		bad_count++;
		$display("unexpected at %0t: timeout", $time);
		results();
	end

	// corner byte pairs first, random ones after
	initial
	begin
		{bad_count, check_count, rl_cnt} = '0;
		{aresetn, par_write_req, s_axi_awvalid, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready, lat, fp, fw} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'h1;
		for (int i = 0; i < 12; i++)
		begin
			{pb, wb} = (i < 4) ? corner[i] : 16'(rnd());
			lat <= 4'(rnd());
			fp <= pb;
			fw <= wb;
			aresetn <= 1'b0;
			repeat (3) @(posedge aclk);
			aresetn <= 1'b1;
			@(posedge aclk);
			chk_cfg(got_cfg(), exp_cfg(8'hff, 8'hff, 1'b0));
			n = 0;
			while (config_valid !== 1'b1 && n < 200)
			begin
				@(posedge aclk);
				n++;
			end
			fp <= ~pb;
			fw <= ~wb;
			want = exp_cfg(pb, wb, 1'b1);
			chk_cfg(got_cfg(), want);
			axi_rd(18'h3_fffc, rsp);
			chk_bus({rsp, rd}, {2'b00, 24'h00_0000, pb});
			axi_rd(18'h3_ff6c, rsp);
			chk_bus({rsp, rd}, {2'b00, 24'h00_0000, wb});
			axi_rd(18'h0_0008, rsp);
			chk_bus({rsp, rd}, {obc_pkg::RESP_SLVERR, 32'h0000_0000});
			axi_rd(18'h0_0004, rsp);
			chk_bus({rsp, rd}, {obc_pkg::RESP_OKAY, 32'h0000_0000});
			axi_wr(18'h3_fffc, 8'h00, rsp);
			chk_bus(34'(rsp), 34'(obc_pkg::RESP_SLVERR));
			axi_wr(18'h0_0000, 8'h00, rsp);
			chk_bus(34'(rsp), 34'(obc_pkg::RESP_OKAY));
			par_write_req <= 1'b1;
			repeat (2) @(posedge aclk);
			chk_bus({33'h0, par_write_allow}, {33'h0, ~prot(pb)});
			axi_rd(18'h0_0000, rsp);
			chk_bus({rsp, rd}, 34'({~prot(pb), prot(pb), 1'b1}));
			par_write_req <= 1'b0;
			rl0 = rl_cnt;
			axi_wr(18'h0_0004, 8'hff, rsp);
			axi_wr(18'h0_0004, 8'h00, rsp);
			s_axi_wstrb <= 4'h0;
			axi_wr(18'h0_0004, 8'hff, rsp);
			s_axi_wstrb <= 4'h1;
			repeat (6) @(posedge aclk);
			chk_cfg(32'(rl_cnt), 32'(rl0));
			axi_wr(18'h0_0004, 8'hff, rsp);
			chk_bus(34'(rsp), 34'(obc_pkg::RESP_OKAY));
			repeat (6) @(posedge aclk);
			chk_cfg(32'(rl_cnt), 32'(rl0 + 1));
			chk_cfg(got_cfg(), want);
		end
		results();
	end
endmodule

// file: obc_pkg.sv
// shared constants and types for the option byte configuration loader
package obc_pkg;

	// flash addresses of the two option bytes
	localparam logic [15:0] FLASH_ADDR_PRI = 16'hFFFF;
	localparam logic [15:0] FLASH_ADDR_WDG = 16'hFFDB;
	// erased flash content, also the safe default
	localparam logic [7:0]  ERASED_BYTE    = 8'hFF;

	// primary byte field positions
	localparam int PRI_AUTOSTART_N = 0;
	localparam int PRI_PROT_CTRL   = 2;
	localparam int PRI_ROM_PROT_N  = 3;
	localparam int PRI_LEVEL_LO    = 4;
	localparam int PRI_LEVEL_HI    = 5;
	localparam int PRI_MON_OFF     = 6;
	localparam int PRI_SRC_OFF     = 7;
	// watchdog byte field positions
	localparam int WDG_UFLOW_LO    = 0;
	localparam int WDG_UFLOW_HI    = 1;
	localparam int WDG_WIN_LO      = 2;
	localparam int WDG_WIN_HI      = 3;

	// watchdog initial counts per underflow period code
	localparam logic [13:0] WDT_INIT_0 = 14'h03FF;
	localparam logic [13:0] WDT_INIT_1 = 14'h0FFF;
	localparam logic [13:0] WDT_INIT_2 = 14'h1FFF;
	localparam logic [13:0] WDT_INIT_3 = 14'h3FFF;

	// refresh sequence bytes
	localparam logic [7:0] REFRESH_FIRST  = 8'h00;
	localparam logic [7:0] REFRESH_SECOND = 8'hFF;

	// register indexes as printed, byte address is four times the index
	localparam logic [17:0] IDX_OPT_WDG  = 18'h0_FFDB;
	localparam logic [17:0] IDX_OPT_PRI  = 18'h0_FFFF;
	localparam logic [17:0] IDX_STATUS   = 18'h0_0000;
	localparam logic [17:0] IDX_REFRESH  = 18'h0_0001;
	localparam int          AXI_AW       = 18;

	// status register bit positions
	localparam int ST_LOADED  = 0;
	localparam int ST_PROTECT = 1;
	localparam int ST_GRANT   = 2;

	// axi response codes
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// fetch sequencer states, one-hot
	typedef enum logic [4:0] {
		FS_RD_PRI   = 5'b0_0001,
		FS_WAIT_PRI = 5'b0_0010,
		FS_RD_WDG   = 5'b0_0100,
		FS_WAIT_WDG = 5'b0_1000,
		FS_DONE     = 5'b1_0000
	} obc_fetch_e;

endpackage

// file: obc_refresh.sv
// detector for the two-write watchdog refresh sequence
`timescale 1ns/1ps
module obc_refresh
(
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       wr_valid,
	input  wire logic [7:0] wr_data,
	output logic            reload
);

	// whole state of the detector
	typedef struct packed {
		logic armed;  // first byte seen
		logic reload; // one-cycle reload pulse
	} obc_refresh_s;

	obc_refresh_s st_ff;
	obc_refresh_s nxt_st;

	// first byte arms, second fires, anything else disarms
	always_comb
	begin
		nxt_st        = st_ff;
		nxt_st.reload = 1'b0;
		if (wr_valid)
		begin
			if (wr_data == obc_pkg::REFRESH_FIRST)
			begin
				nxt_st.armed = 1'b1;
			end
			else if (st_ff.armed && wr_data == obc_pkg::REFRESH_SECOND)
			begin
				nxt_st.armed  = 1'b0;
				nxt_st.reload = 1'b1; // [RQ15]
			end
			else
			begin
				nxt_st.armed = 1'b0;
			end
		end
	end

	// register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_ff <= '0;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	assign reload = st_ff.reload;

endmodule
